/* core/rdrf_defs.svh */
// Constants for the radar distance report framer.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef RDRF_DEFS_SVH
`define RDRF_DEFS_SVH
`define RDRF_CLK_HZ        100000000
`define RDRF_BAUD          115200
`define RDRF_BIT_CYCLES    (`RDRF_CLK_HZ / `RDRF_BAUD)
`define RDRF_INIT_S        25
`define RDRF_REPORT_MS     1000
`define RDRF_IDLE_S        60
`define RDRF_INIT_CYCLES   (`RDRF_INIT_S * `RDRF_CLK_HZ)
`define RDRF_REPORT_CYCLES (`RDRF_REPORT_MS * (`RDRF_CLK_HZ / 1000))
`define RDRF_IDLE_REPORTS  `RDRF_IDLE_S
`define RDRF_BYTE_START    8'h ff
`define RDRF_BYTE_END      8'h fe
`define RDRF_CODE_SETTING  8'h 30
`define RDRF_CODE_OPER     8'h 31
`define RDRF_BOARD_ID      8'h 42
`define RDRF_NO_PERSON_CM  14'd812
`define RDRF_MIN_CM        14'd50
`define RDRF_MAX_CM        14'd800
`define RDRF_SET_LEN       4'd3
`define RDRF_OPER_LEN      4'd7
`endif

/* core/rdrf_pkg.sv */
// Types for the radar distance report framer.
// Constants live in rdrf_defs.svh.
package rdrf_pkg;
  typedef enum logic [4:0] {
    RDRF_IDLE = 5'b0_0001,
    RDRF_HEAD = 5'b0_0010,
    RDRF_BODY = 5'b0_0100,
    RDRF_TAIL = 5'b0_1000,
    RDRF_WAIT = 5'b1_0000
  } rdrf_state_t;
endpackage : rdrf_pkg

/* core/rdrf_uart_tx.sv */
// Serial byte transmitter, 8N1, LSB first.
// Assumes one clock; bit time given as cycle count.
`timescale 1ns/1ps
module rdrf_uart_tx #(
  parameter int BIT_CYCLES = 868
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  // Byte in
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  // Line
  output logic            serial_tx
);
  logic [9:0]  shift_q;
  logic [3:0]  bits_q;
  logic [15:0] baud_q;
  wire         busy     = (bits_q != 4'd0);
  wire         bit_done = (baud_q == 16'(BIT_CYCLES - 1));

  assign tx_ready = !busy;

  // Frame shifter: start, data LSB first, stop
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      shift_q   <= 10'h 3ff;
      bits_q    <= 4'd0;
      baud_q    <= 16'h 0000;
      serial_tx <= 1'b1;
    end else if (clk_en) begin
      if (!busy && tx_valid) begin
        shift_q   <= {1'b1, tx_data, 1'b0};
        bits_q    <= 4'd10;
        baud_q    <= 16'h 0000;
        serial_tx <= 1'b0;
      end else if (busy) begin
        if (bit_done) begin
          baud_q    <= 16'h 0000;
          bits_q    <= bits_q - 4'd1;
          shift_q   <= {1'b1, shift_q[9:1]};
          serial_tx <= (bits_q == 4'd1) ? 1'b1 : shift_q[1];
        end else begin
          baud_q <= baud_q + 16'd1;
        end
      end
    end
  end
endmodule : rdrf_uart_tx

/* core/rdrf_framer.sv */
// Report framer: initial setting, then periodic distance reports.
// Assumes distance samples come from logic on the same clock.
`timescale 1ns/1ps
`include "rdrf_defs.svh"
module rdrf_framer #(
  parameter int INIT_CYCLES   = `RDRF_INIT_CYCLES,
  parameter int REPORT_CYCLES = `RDRF_REPORT_CYCLES,
  parameter int IDLE_REPORTS  = `RDRF_IDLE_REPORTS,
  parameter int BIT_CYCLES    = `RDRF_BIT_CYCLES,
  parameter logic [7:0] BOARD_ID = `RDRF_BOARD_ID // Arbitrary value
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  // Motion samples from detector
  input  wire logic        motion_valid,
  input  wire logic [13:0] motion_cm,
  input  wire logic [13:0] motion_frac,
  // Status
  output logic             setting_done,
  // Serial line
  output logic             serial_tx
);
  rdrf_pkg::rdrf_state_t state_q;
  logic [31:0] tick_q;
  logic [31:0] init_q;
  logic [6:0]  pct_q;
  logic [7:0]  quiet_q;
  logic [13:0] near_q, near_f_q, rep_q, rep_f_q;
  logic        seen_q;
  logic [3:0]  idx_q;
  logic [7:0]  byte_q;
  logic        send_q;
  logic        tx_ready;
  logic        in_body_q;
  logic        oper_q;
  logic [6:0]  pct_s_q;

  // Sample acceptance window
  wire in_range = (motion_cm > `RDRF_MIN_CM) &&
                  (motion_cm <= `RDRF_MAX_CM);
  wire take     = motion_valid && in_range && setting_done;
  wire closer   = !seen_q || (motion_cm < near_q);
  wire tick     = (tick_q == 32'(REPORT_CYCLES - 1));
  wire init_end = (init_q == 32'(INIT_CYCLES - 1));
  wire quiet    = (quiet_q >= 8'(IDLE_REPORTS - 1));
  wire launch   = tick && (state_q == rdrf_pkg::RDRF_IDLE);
  wire [13:0] frac_c = (motion_frac > 14'd99) ? 14'd99 : motion_frac;
  wire [3:0] plen = oper_q ? `RDRF_OPER_LEN : `RDRF_SET_LEN;

  // Decimal digits of the values being reported
  wire [13:0] ip = rep_q;
  wire [7:0] d3 = 8'h 30 + 8'(ip / 14'd1000);
  wire [7:0] d2 = 8'h 30 + 8'((ip / 14'd100) % 14'd10);
  wire [7:0] d1 = 8'h 30 + 8'((ip / 14'd10) % 14'd10);
  wire [7:0] d0 = 8'h 30 + 8'(ip % 14'd10);
  wire [7:0] f1 = 8'h 30 + 8'((rep_f_q / 14'd10) % 14'd10);
  wire [7:0] f0 = 8'h 30 + 8'(rep_f_q % 14'd10);
  wire [7:0] p2 = 8'h 30 + 8'(pct_s_q / 7'd100);
  wire [7:0] p1 = 8'h 30 + 8'((pct_s_q / 7'd10) % 7'd10);
  wire [7:0] p0 = 8'h 30 + 8'(pct_s_q % 7'd10);

  // Payload byte selection
  logic [7:0] pay;
  always_comb begin
    pay = 8'h 30;
    if (oper_q) begin
      unique case (idx_q)
        4'd0: pay = d3;
        4'd1: pay = d2;
        4'd2: pay = d1;
        4'd3: pay = d0;
        4'd4: pay = 8'h 2e;
        4'd5: pay = f1;
        default: pay = f0;
      endcase
    end else begin
      unique case (idx_q)
        4'd0: pay = p2;
        4'd1: pay = p1;
        default: pay = p0;
      endcase
    end
  end

  // Header byte selection
  wire [7:0] code = oper_q ? `RDRF_CODE_OPER : `RDRF_CODE_SETTING;
  wire [7:0] head = (idx_q == 4'd0) ? `RDRF_BYTE_START :
                    (idx_q == 4'd1) ? BOARD_ID : code;

  // Report period and setting timers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tick_q       <= 32'h 0000_0000;
      init_q       <= 32'h 0000_0000;
      setting_done <= 1'b0;
      pct_q        <= 7'd0;
    end else if (clk_en) begin
      tick_q <= tick ? 32'h 0000_0000 : tick_q + 32'd1;
      if (!setting_done) begin
        init_q       <= init_q + 32'd1;
        setting_done <= init_end;
        pct_q        <= init_end ? 7'd100 :
                        7'((64'(init_q) * 64'd100) / 64'(INIT_CYCLES));
      end
    end
  end

  // Nearest target tracking and absence timer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      near_q   <= `RDRF_NO_PERSON_CM;
      near_f_q <= 14'd0;
      rep_q    <= `RDRF_NO_PERSON_CM;
      rep_f_q  <= 14'd0;
      seen_q   <= 1'b0;
      quiet_q  <= 8'h 00;
    end else if (clk_en) begin
      if (launch) begin
        seen_q   <= take;                                  // Opens new window
        if (take) begin
          near_q   <= motion_cm;
          near_f_q <= frac_c;
        end
        quiet_q  <= (seen_q || take) ? 8'h 00 :
                    (quiet ? quiet_q : quiet_q + 8'd1);
        if (seen_q) begin
          rep_q   <= near_q;
          rep_f_q <= near_f_q;
        end else if (quiet) begin
          rep_q   <= `RDRF_NO_PERSON_CM;
          rep_f_q <= 14'd0;
        end
      end else if (take && closer) begin
        near_q   <= motion_cm;
        near_f_q <= frac_c;
        seen_q   <= 1'b1;
      end
    end
  end

  // Packet sequencer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= rdrf_pkg::RDRF_IDLE;
      idx_q   <= 4'd0;
      byte_q  <= 8'h 00;
      send_q  <= 1'b0;
    end else if (clk_en) begin
      if (send_q && tx_ready) begin
        send_q <= 1'b0;
      end
      unique case (state_q)
        rdrf_pkg::RDRF_IDLE: begin
          if (tick) begin
            state_q <= rdrf_pkg::RDRF_HEAD;
            idx_q   <= 4'd0;
          end
        end
        rdrf_pkg::RDRF_HEAD: begin
          if (!send_q) begin
            byte_q <= head;
            send_q <= 1'b1;
            state_q <= rdrf_pkg::RDRF_WAIT;
          end
        end
        rdrf_pkg::RDRF_BODY: begin
          if (!send_q) begin
            byte_q  <= (idx_q == plen) ? `RDRF_BYTE_END : pay;
            send_q  <= 1'b1;
            state_q <= (idx_q == plen) ? rdrf_pkg::RDRF_TAIL
                                       : rdrf_pkg::RDRF_WAIT;
          end
        end
        rdrf_pkg::RDRF_TAIL: begin
          if (!send_q) begin
            state_q <= rdrf_pkg::RDRF_IDLE;
            idx_q   <= 4'd0;
          end
        end
        rdrf_pkg::RDRF_WAIT: begin
          if (send_q && tx_ready) begin
            if (idx_q == 4'd2 && !in_body_q) begin         // Header done
              idx_q   <= 4'd0;
              state_q <= rdrf_pkg::RDRF_BODY;
            end else if (!in_body_q) begin
              idx_q   <= idx_q + 4'd1;
              state_q <= rdrf_pkg::RDRF_HEAD;
            end else begin
              idx_q   <= idx_q + 4'd1;
              state_q <= rdrf_pkg::RDRF_BODY;
            end
          end
        end
      endcase
    end
  end

  // Mode and progress held steady for the whole packet
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      oper_q  <= 1'b0;
      pct_s_q <= 7'd0;
    end else if (clk_en && launch) begin
      oper_q  <= setting_done;
      pct_s_q <= pct_q;
    end
  end

  // Marks that the header is done and payload bytes are flowing
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      in_body_q <= 1'b0;
    end else if (clk_en) begin
      if (state_q == rdrf_pkg::RDRF_IDLE) begin
        in_body_q <= 1'b0;
      end else if (state_q == rdrf_pkg::RDRF_BODY) begin
        in_body_q <= 1'b1;
      end
    end
  end

  // Serial transmitter
  rdrf_uart_tx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_tx (
    .clock     (clock),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .tx_valid  (send_q),
    .tx_data   (byte_q),
    .tx_ready  (tx_ready),
    .serial_tx (serial_tx)
  );
endmodule : rdrf_framer

/* tb/rdrf_framer_props.sv */
// Checker on the framer ports.
// Counts only cycles with clk_en high, as the design does.
`timescale 1ns/1ps
module rdrf_framer_props #(
  parameter int INIT_CYCLES   = 5000,
  parameter int REPORT_CYCLES = 2000,
  parameter int BIT_CYCLES    = 8
) (
  // Clock, reset and inputs
  input wire logic        clock, reset_n, clk_en, motion_valid,
  input wire logic [13:0] motion_cm, motion_frac,
  // Outputs
  input wire logic        setting_done, serial_tx
);
  int cnt_q;
  int low_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Cycles since reset and length of the current low run
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 0;
      low_q <= 0;
    end else if (clk_en) begin
      cnt_q <= cnt_q + 1;
      low_q <= serial_tx ? 0 : low_q + 1;
    end
  end
  property p_rst; $rose(reset_n) |-> serial_tx && !setting_done; endproperty
  a_rst: assert property (p_rst) else $error("busy after reset");
  property p_quiet; cnt_q < REPORT_CYCLES - 1 |-> serial_tx; endproperty
  a_quiet: assert property (p_quiet) else $error("early output");
  property p_first; cnt_q == REPORT_CYCLES |-> ##[0:6] !serial_tx; endproperty
  a_first: assert property (p_first) else $error("no output");
  property p_tick;
    setting_done && cnt_q % REPORT_CYCLES == REPORT_CYCLES - 4
      |-> ##[1:10] $fell(serial_tx);
  endproperty
  a_tick: assert property (p_tick) else $error("report missed");
  property p_hold; setting_done |=> setting_done; endproperty
  a_hold: assert property (p_hold) else $error("done dropped");
  property p_early; setting_done |-> cnt_q >= INIT_CYCLES - 2; endproperty
  a_early: assert property (p_early) else $error("done early");
  property p_late; cnt_q == INIT_CYCLES + 2 |-> setting_done; endproperty
  a_late: assert property (p_late) else $error("done late");
  property p_start; $fell(serial_tx) |-> !serial_tx [*8]; endproperty
  a_start: assert property (p_start) else $error("short start");
  property p_whole;
    $rose(serial_tx) |-> low_q % BIT_CYCLES == 0 && low_q <= 9 * BIT_CYCLES;
  endproperty
  a_whole: assert property (p_whole) else $error("bad bits");
  property p_stop; $rose(serial_tx) |-> serial_tx [*8]; endproperty
  a_stop: assert property (p_stop) else $error("short stop");
  cover property (motion_valid && setting_done);
endmodule : rdrf_framer_props
bind rdrf_framer rdrf_framer_props #(.INIT_CYCLES(INIT_CYCLES),
  .REPORT_CYCLES(REPORT_CYCLES), .BIT_CYCLES(BIT_CYCLES)) u_props (
  .clock(clock), .reset_n(reset_n), .clk_en(clk_en),
  .motion_valid(motion_valid), .motion_cm(motion_cm),
  .motion_frac(motion_frac), .setting_done(setting_done),
  .serial_tx(serial_tx));

/* tb/rdrf_host_rx.sv */
// Host receiver model: 8N1, LSB first, samples mid bit.
// Assumes the bit time in cycles is given by parameter.
`timescale 1ns/1ps
module rdrf_host_rx #(
  parameter int BIT_CYCLES = 8
) (
  // Clock and line
  input wire logic  clock, reset_n, serial_rx,
  // Decoded bytes, sticky stop bit fault
  output logic       rx_valid, frame_err,
  output logic [7:0] rx_data
);
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  int         cnt_q;
  // Start detect, eight data bits, stop check
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      {bit_q, sh_q, cnt_q, rx_valid, frame_err, rx_data} <= '0;
    end else begin
      rx_valid <= 1'b0;
      if (bit_q == 4'h0) begin
        if (!serial_rx) begin
          bit_q <= 4'h1;
          cnt_q <= BIT_CYCLES / 2 + BIT_CYCLES - 1;
        end
      end else if (cnt_q != 0) cnt_q <= cnt_q - 1;
      else if (bit_q <= 4'h8) begin
        sh_q  <= {serial_rx, sh_q[7:1]};
        bit_q <= bit_q + 4'h1;
        cnt_q <= BIT_CYCLES - 1;
      end else begin
        rx_data  <= sh_q;
        rx_valid <= 1'b1;
        frame_err <= frame_err | !serial_rx;
        bit_q    <= 4'h0;
      end
    end
  end
endmodule : rdrf_host_rx

/* tb/rdrf_framer_tb_top.sv */
// Bench: setting, nearest distance, idle and reset cases.
// Assumes the host model decodes serial_tx into bytes.
`timescale 1ns/1ps
`include "rdrf_defs.svh"
module rdrf_framer_tb_top;
  localparam int TICK = 2000;
  localparam int INIT = 5000;
  localparam logic [7:0] BID = 8'h5a; // Arbitrary value
  logic        clock, reset_n, clk_en, motion_valid, setting_done, serial_tx;
  logic        rx_valid, frame_err;
  logic [13:0] motion_cm, motion_frac;
  logic [7:0]  rx_data;
  logic [7:0]  cur[$], pkt[$];
  int          pkt_n, fail_count, n_checks, cyc;
  rdrf_framer #(.INIT_CYCLES(INIT), .REPORT_CYCLES(TICK), .IDLE_REPORTS(3),
    .BIT_CYCLES(8), .BOARD_ID(BID)) u_dut (.clock(clock), .reset_n(reset_n),
    .clk_en(clk_en), .motion_valid(motion_valid), .motion_cm(motion_cm),
    .motion_frac(motion_frac), .setting_done(setting_done),
    .serial_tx(serial_tx));
  rdrf_host_rx #(.BIT_CYCLES(8)) u_host (.clock(clock), .reset_n(reset_n),
    .serial_rx(serial_tx), .rx_valid(rx_valid), .rx_data(rx_data),
    .frame_err(frame_err));
  // Clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Gather bytes into packets, cut hangs short
  always @(negedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      complete_run();
    end
    if (rx_valid) cur.push_back(rx_data);
    if (rx_valid && rx_data === `RDRF_BYTE_END) begin
      pkt = cur;
      cur = {};
      pkt_n++;
    end
  end
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wait_pkt();
    int n = pkt_n;
    repeat (3 * TICK) if (pkt_n == n) @(negedge clock);
    chk("packet", 8'h01, 8'(pkt_n != n));
  endtask : wait_pkt
  task automatic chk_frame(logic [7:0] code, int len);
    chk("start", `RDRF_BYTE_START, pkt[0]);
    chk("board", BID, pkt[1]);
    chk("code", code, pkt[2]);
    chk("length", 8'(len + 4), 8'(pkt.size()));
  endtask : chk_frame
  task automatic chk_dist(int cm, int fr);
    int v = cm * 100 + fr;
    wait_pkt();
    chk_frame(`RDRF_CODE_OPER, 7);
    for (int i = 6; i >= 0; i--) begin
      if (i == 4) chk("point", 8'h2e, pkt[3+i]);
      else begin
        chk("digit", 8'(48 + v % 10), pkt[3+i]);
        v = v / 10;
      end
    end
  endtask : chk_dist
  task automatic send(int cm, int fr);
    @(negedge clock);
    {motion_valid, motion_cm, motion_frac} = {1'b1, 14'(cm), 14'(fr)};
    @(negedge clock);
    motion_valid = 1'b0;
  endtask : send
  task automatic t_setting();
    int v;
    int e = 100 * TICK / INIT;
    wait_pkt();
    chk_frame(`RDRF_CODE_SETTING, 3);
    v = (pkt[3] - 48) * 100 + (pkt[4] - 48) * 10 + pkt[5] - 48;
    chk("percent", 8'h01, 8'(v >= e - 1 && v <= e));
    chk("done", 8'h00, 8'(setting_done));
  endtask : t_setting
  task automatic t_nearest();
    repeat (6000) if (setting_done !== 1'b1) @(negedge clock);
    chk("done", 8'h01, 8'(setting_done));
    wait_pkt();
    send(900, 0);
    send(50, 0);
    send(800, 0);
    chk_dist(800, 0);
    send(300, 25);
    send(51, 0);
    send(120, 99);
    chk_dist(51, 0);
    chk_dist(51, 0);
    chk_dist(51, 0);
    chk_dist(812, 0);
  endtask : t_nearest
  task automatic t_freeze();
    int bad = 0;
    @(negedge clock);
    clk_en = 1'b0;
    repeat (500) begin
      @(negedge clock);
      if (serial_tx !== 1'b1 || setting_done !== 1'b1) bad++;
    end
    chk("frozen", 8'h00, 8'(bad != 0));
    clk_en = 1'b1;
    chk_dist(812, 0);
  endtask : t_freeze
  task automatic t_reset();
    repeat (3 * TICK) if (serial_tx !== 1'b0) @(negedge clock);
    chk("stop", 8'h00, 8'(frame_err));
    reset_n = 1'b0;
    repeat (3) @(negedge clock);
    cur = {};
    reset_n = 1'b1;
    chk("done", 8'h00, 8'(setting_done));
    chk("idle", 8'h01, 8'(serial_tx));
    t_setting();
    chk("stop", 8'h00, 8'(frame_err));
  endtask : t_reset
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // Main sequence
  initial begin
    {reset_n, motion_valid, motion_cm, motion_frac} = '0;
    clk_en = 1'b1;
    {pkt_n, fail_count, n_checks, cyc} = '0;
    repeat (8) @(negedge clock);
    reset_n = 1'b1;
    t_setting();
    t_nearest();
    t_freeze();
    t_reset();
    complete_run();
  end
endmodule : rdrf_framer_tb_top
